// ---- hdl/pdc_decode.sv ----
`timescale 1ns/1ps
`include "pdc_defs.svh"

module pdc_decode (
  // Raw word
  input wire logic [31:0] word,
  input wire logic usb_present,
  // Decoded settings
  output pdc_pkg::pdc_pll_cfg_t cfg
);

  always_comb begin
    cfg = '0;
    case (word[`PDC_ODIV_HI:`PDC_ODIV_LO])
      3'h0: cfg.out_divisor = 9'h001;
      3'h1: cfg.out_divisor = 9'h002;
      3'h2: cfg.out_divisor = 9'h004;
      3'h3: cfg.out_divisor = 9'h008;
      3'h4: cfg.out_divisor = 9'h010;
      3'h5: cfg.out_divisor = 9'h020;
      3'h6: cfg.out_divisor = 9'h040;
      default: cfg.out_divisor = 9'h100;
    endcase
    case (word[`PDC_MUL_HI:`PDC_MUL_LO])
      3'h0: cfg.multiplier = 5'h0f;
      3'h1: cfg.multiplier = 5'h10;
      3'h2: cfg.multiplier = 5'h11;
      3'h3: cfg.multiplier = 5'h12;
      3'h4: cfg.multiplier = 5'h13;
      3'h5: cfg.multiplier = 5'h14;
      3'h6: cfg.multiplier = 5'h15;
      default: cfg.multiplier = 5'h18;
    endcase
    cfg.input_div_code = word[`PDC_IDIV_HI:`PDC_IDIV_LO];
    // Without the USB function the USB PLL stays bypassed at unity division.
    cfg.usb_bypass = usb_present ? word[`PDC_UBYP_BIT] : 1'b1;
    if (usb_present) begin
      case (word[`PDC_UDIV_HI:`PDC_UDIV_LO])
        3'h0: cfg.usb_input_divisor = 4'h1;
        3'h1: cfg.usb_input_divisor = 4'h2;
        3'h2: cfg.usb_input_divisor = 4'h3;
        3'h3: cfg.usb_input_divisor = 4'h4;
        3'h4: cfg.usb_input_divisor = 4'h5;
        3'h5: cfg.usb_input_divisor = 4'h6;
        3'h6: cfg.usb_input_divisor = 4'ha;
        default: cfg.usb_input_divisor = 4'hc;
      endcase
    end else begin
      cfg.usb_input_divisor = 4'h1;
    end
  end

endmodule

// ---- hdl/pdc_defs.svh ----
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// Field positions of the configuration word.
`define PDC_ODIV_HI 18
`define PDC_ODIV_LO 16
`define PDC_UBYP_BIT 15
`define PDC_UDIV_HI 10
`define PDC_UDIV_LO 8
`define PDC_MUL_HI 6
`define PDC_MUL_LO 4
`define PDC_IDIV_HI 2
`define PDC_IDIV_LO 0

// Bits that must be programmed to one.
`define PDC_RSVD_MASK 32'hfff87888

// Erased word: every bit one.
`define PDC_ERASED_WORD 32'hffffffff

// Sampling cycles before a synchronised input may be taken.
`define PDC_SYNC_FILL 2'h3

// Register byte addresses.
`define PDC_ADDR_WORD 12'h000
`define PDC_ADDR_STATUS 12'h004
`define PDC_ADDR_DECODED 12'h008
`define PDC_ADDR_RELOAD 12'h00c

`endif

// ---- hdl/pdc_pkg.sv ----
package pdc_pkg;

  typedef struct packed {
    logic [8:0] out_divisor;
    logic [4:0] multiplier;
    logic [2:0] input_div_code;
    logic usb_bypass;
    logic [3:0] usb_input_divisor;
  } pdc_pll_cfg_t;

  typedef enum {
    PDC_ST_IDLE,
    PDC_ST_LOAD,
    PDC_ST_DONE
  } pdc_state_t;

endpackage

// ---- hdl/pdc_top.sv ----
`timescale 1ns/1ps
`include "pdc_defs.svh"

module pdc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Nonvolatile word and variant strap
  input wire logic [31:0] nv_word,
  input wire logic usb_present,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Settings to the clock unit
  output pdc_pkg::pdc_pll_cfg_t pll_cfg,
  output logic cfg_valid
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  // Word and strap come from outside this clock domain. Each passes three
  // flip-flops, and a value is only taken while stages two and three agree.
  logic [31:0] wsync1_reg, wsync1_next;
  logic [31:0] wsync2_reg, wsync2_next;
  logic [31:0] wsync3_reg, wsync3_next;
  logic usync1_reg, usync1_next;
  logic usync2_reg, usync2_next;
  logic usync3_reg, usync3_next;
  logic sync_agree;

  always_comb begin
    wsync1_next = nv_word;
    wsync2_next = wsync1_reg;
    wsync3_next = wsync2_reg;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wsync1_reg <= `PDC_ERASED_WORD;
      wsync2_reg <= `PDC_ERASED_WORD;
      wsync3_reg <= `PDC_ERASED_WORD;
    end else begin
      wsync1_reg <= wsync1_next;
      wsync2_reg <= wsync2_next;
      wsync3_reg <= wsync3_next;
    end
  end

  always_comb begin
    usync1_next = usb_present;
    usync2_next = usync1_reg;
    usync3_next = usync2_reg;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      usync1_reg <= 1'b0;
      usync2_reg <= 1'b0;
      usync3_reg <= 1'b0;
    end else begin
      usync1_reg <= usync1_next;
      usync2_reg <= usync2_next;
      usync3_reg <= usync3_next;
    end
  end

  assign sync_agree = (wsync2_reg == wsync3_reg) && (usync2_reg == usync3_reg);

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------

  pdc_pkg::pdc_state_t state_reg, state_next;
  logic [31:0] word_reg, word_next;
  logic usb_reg, usb_next;
  pdc_pkg::pdc_pll_cfg_t cfg_reg, cfg_next;
  logic rsvd_err_reg, rsvd_err_next;
  logic [1:0] fill_reg, fill_next;
  logic reload_req;
  pdc_pkg::pdc_pll_cfg_t dec_cfg;

  pdc_decode u_decode (
    .word(word_reg),
    .usb_present(usb_reg),
    .cfg(dec_cfg)
  );

  always_comb begin
    state_next = state_reg;
    word_next = word_reg;
    usb_next = usb_reg;
    cfg_next = cfg_reg;
    rsvd_err_next = rsvd_err_reg;
    fill_next = fill_reg;
    case (state_reg)
      pdc_pkg::PDC_ST_IDLE: begin
        // The chain is filled with fresh samples before anything is taken.
        if (fill_reg != `PDC_SYNC_FILL) begin
          fill_next = fill_reg + 2'h1;
        end else if (sync_agree) begin
          word_next = wsync3_reg;
          usb_next = usync3_reg;
          state_next = pdc_pkg::PDC_ST_LOAD;
        end
      end
      pdc_pkg::PDC_ST_LOAD: begin
        cfg_next = dec_cfg;
        // Flags a word whose reserved bits were not all programmed to one.
        rsvd_err_next = (word_reg & `PDC_RSVD_MASK) != `PDC_RSVD_MASK;
        state_next = pdc_pkg::PDC_ST_DONE;
      end
      pdc_pkg::PDC_ST_DONE: begin
        if (reload_req) begin
          state_next = pdc_pkg::PDC_ST_IDLE;
          // A reload waits for a full new pass through the synchronisers.
          fill_next = 2'h0;
        end
      end
      default: state_next = pdc_pkg::PDC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= pdc_pkg::PDC_ST_IDLE;
      word_reg <= `PDC_ERASED_WORD;
      usb_reg <= 1'b0;
      cfg_reg <= '0;
      rsvd_err_reg <= 1'b0;
      fill_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      word_reg <= word_next;
      usb_reg <= usb_next;
      cfg_reg <= cfg_next;
      rsvd_err_reg <= rsvd_err_next;
      fill_reg <= fill_next;
    end
  end

  assign pll_cfg = cfg_reg;
  assign cfg_valid = (state_reg == pdc_pkg::PDC_ST_DONE);

  // ----------------------------------------------------------------
  // Readback words
  // ----------------------------------------------------------------

  logic [31:0] status_word;
  logic [31:0] decoded_word;

  assign status_word = {29'h0, usb_reg, rsvd_err_reg, cfg_valid};
  assign decoded_word = {10'h0, cfg_reg};

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------

  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic setup;
  logic access;
  logic hit_reload;

  assign setup = psel && !penable;
  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign access = psel && penable;
  assign hit_reload = (paddr == `PDC_ADDR_RELOAD);
  assign pslverr = access && err_reg;
  // A refused access never starts a reload.
  assign reload_req = access && pwrite && !err_reg && hit_reload && pwdata[0];

  // Read data and the error answer are prepared in the setup cycle.
  always_comb begin
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (setup) begin
      rdata_next = 32'h0;
      err_next = 1'b0;
      case (paddr)
        `PDC_ADDR_WORD: begin
          rdata_next = word_reg;
          err_next = pwrite;
        end
        `PDC_ADDR_STATUS: begin
          rdata_next = status_word;
          err_next = pwrite;
        end
        `PDC_ADDR_DECODED: begin
          rdata_next = decoded_word;
          err_next = pwrite;
        end
        `PDC_ADDR_RELOAD: begin
          err_next = !pwrite;
        end
        default: err_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h0;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

endmodule

// ---- verification/pdc_top_sva.sv ----
`timescale 1ns/1ps
module pdc_top_sva (
  // Watched ports
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [31:0] nv_word,
  input wire logic usb_present,
  input wire pdc_pkg::pdc_pll_cfg_t pll_cfg,
  input wire logic cfg_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_ODIV: assert property ($rose(cfg_valid) |->
    pll_cfg.out_divisor == (&nv_word[18:16] ? 9'h100 : 9'h1 << nv_word[18:16]))
    else $error("odiv");
  AST_UBYP: assert property ($rose(cfg_valid) |->
    pll_cfg.usb_bypass == (nv_word[15] | !usb_present)) else $error("bypass");
  AST_UDIV: assert property ($rose(cfg_valid) && usb_present |->
    pll_cfg.usb_input_divisor == (nv_word[10:9] == 2'h3 ? (nv_word[8] ? 4'hc : 4'ha) :
    {1'b0, nv_word[10:8]} + 4'h1)) else $error("udiv");
  AST_MUL: assert property ($rose(cfg_valid) |->
    pll_cfg.multiplier == (&nv_word[6:4] ? 5'h18 : 5'h0f + nv_word[6:4])) else $error("mul");
  AST_NOUSB: assert property ($rose(cfg_valid) && !usb_present |->
    pll_cfg.usb_input_divisor == 4'h1) else $error("no usb");
  AST_LOAD: assert property ($rose(resetn) |-> ##[1:8] cfg_valid) else $error("load");
  AST_IDIV: assert property ($rose(cfg_valid) |->
    pll_cfg.input_div_code == nv_word[2:0]) else $error("idiv");
endmodule
bind pdc_top pdc_top_sva pdc_top_sva_i (.mclk(mclk), .resetn(resetn), .nv_word(nv_word),
  .usb_present(usb_present), .pll_cfg(pll_cfg), .cfg_valid(cfg_valid));

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, usb_present = 1;
  logic pready, pslverr, cfg_valid, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, nv_word = '1, prdata, rd;
  pdc_pkg::pdc_pll_cfg_t pll_cfg;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  pdc_top pdc_top_i (.mclk(mclk), .resetn(resetn), .nv_word(nv_word), .usb_present(usb_present),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pll_cfg(pll_cfg), .cfg_valid(cfg_valid));
  always #2.5 mclk = ~mclk;
  task summarize();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk) if (++cyc == 3000) begin
    num_errors++;
    summarize();
  end
  task chk(string nm, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, s);
      num_errors++;
    end
  endtask
  task apb(logic w, logic [11:0] a);
    @(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 32'h1};
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task wvalid();
    repeat (3) @(negedge mclk);
    while (cfg_valid !== 1'b1) @(negedge mclk);
  endtask
  function automatic logic [31:0] ecfg(logic [2:0] c, logic u);
    int od[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
    int ml[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
    int ud[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
    return {10'h0, 9'(od[c]), 5'(ml[c]), c, u ? c[0] : 1'b1, u ? 4'(ud[c]) : 4'h1};
  endfunction
  initial begin
    repeat (8) @(posedge mclk);
    chk("rst_cfg", 32'h0, {9'h0, cfg_valid, pll_cfg});
    resetn <= 1'b1;
    wvalid();
    chk("pll_cfg", ecfg(3'h7, 1'b1), {10'h0, pll_cfg});
    $display("reset test done");
    for (int u = 1; u >= 0; u--) for (int c = 0; c < 8; c++) begin
      @(posedge mclk) nv_word <= {13'h1fff, c[2:0], c[0], 4'hf, c[2:0], 1'b1,
        c[2:0], 1'b1, c[2:0]};
      usb_present <= u[0];
      apb(1'b1, 12'h00c);
      @(negedge mclk) chk("cfg_drop", 32'h0, {31'h0, cfg_valid});
      wvalid();
      chk("pll_cfg", ecfg(c[2:0], u[0]), {10'h0, pll_cfg});
      apb(1'b0, 12'h004);
      chk("status", {29'h0, u[0], 2'h1}, rd);
      chk("status_err", 32'h0, {31'h0, er});
    end
    $display("decode test done");
    @(posedge mclk) nv_word <= 32'h7fffffff;
    apb(1'b1, 12'h00c);
    wvalid();
    apb(1'b0, 12'h004);
    chk("status", 32'h3, rd);
    apb(1'b0, 12'h008);
    chk("decoded", ecfg(3'h7, 1'b0), rd);
    apb(1'b1, 12'h000);
    chk("wr_err", 32'h1, {31'h0, er});
    apb(1'b0, 12'h010);
    chk("map_err", 32'h1, {31'h0, er});
    apb(1'b0, 12'h000);
    chk("raw", 32'h7fffffff, rd);
    chk("raw_err", 32'h0, {31'h0, er});
    apb(1'b0, 12'h00c);
    chk("reload_rd_err", 32'h1, {31'h0, er});
    $display("register test done");
    summarize();
  end
endmodule
